// ---- lptc_top.sv ----
// threshold registers, result registers and interrupt flag logic
`timescale 1ns/1ps

module lptc_top #(
    parameter int PROX_W = 8,
    parameter int LIGHT_W = 12
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr_en,
    input wire logic [7:0] i_reg_wr_data,
    input wire logic i_reg_rd_en,
    input wire logic i_prox_valid,
    input wire logic [7:0] i_prox_data,
    input wire logic i_light_valid,
    input wire logic [11:0] i_light_data,
    output logic [7:0] o_reg_rd_data,
    output logic o_int_o,
    output logic o_int_oe
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // register layout is fixed at an 8-bit prox and a 12-bit light result
    if (PROX_W != 8 || LIGHT_W != 12) begin : g_bad_width
        $error("lptc_top: PROX_W must be 8 and LIGHT_W must be 12");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] prst_count(input logic [1:0] sel);
        logic [4:0] n;
        n = lptc_pkg::PRST_N1;
        unique case (sel)
            2'b00: n = lptc_pkg::PRST_N1;
            2'b01: n = lptc_pkg::PRST_N4;
            2'b10: n = lptc_pkg::PRST_N8;
            2'b11: n = lptc_pkg::PRST_N16;
        endcase
        return n;
    endfunction

    // saturating run counter: counts a condition held over consecutive results
    function automatic logic [4:0] run_next(input logic [4:0] cnt, input logic cond);
        logic [4:0] r;
        r = 5'h00;
        if (cond) begin
            r = (cnt == lptc_pkg::PRST_N16) ? cnt : 5'(cnt + 5'h01);
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] prox_low_threshold_ff;
    logic [7:0] prox_high_threshold_ff;
    logic [7:0] light_low_threshold_low_byte_ff;
    logic [7:0] light_threshold_shared_nibbles_ff;
    logic [7:0] light_high_threshold_high_byte_ff;
    logic [7:0] prox_result_ff;
    logic [11:0] light_result_ff;
    logic prox_flag_ff;
    logic light_window_flag_ff;
    logic [1:0] prox_prst_ff;
    logic [1:0] light_prst_ff;
    logic int_and_ff;
    logic [4:0] prox_near_cnt_ff;
    logic [4:0] prox_far_cnt_ff;
    logic [4:0] light_out_cnt_ff;
    logic [7:0] o_reg_rd_data_ff;
    logic o_int_oe_ff;

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    wire wr_int = i_reg_wr_en && (i_reg_addr == lptc_pkg::ADDR_INT_CTRL);
    wire wr_ptl = i_reg_wr_en && (i_reg_addr == lptc_pkg::ADDR_PROX_LOW_THRESHOLD);
    wire wr_pth = i_reg_wr_en && (i_reg_addr == lptc_pkg::ADDR_PROX_HIGH_THRESHOLD);
    wire wr_ll = i_reg_wr_en && (i_reg_addr == lptc_pkg::ADDR_LIGHT_LOW_LSB);
    wire wr_ls = i_reg_wr_en && (i_reg_addr == lptc_pkg::ADDR_LIGHT_SHARED);
    wire wr_lh = i_reg_wr_en && (i_reg_addr == lptc_pkg::ADDR_LIGHT_HIGH_MSB);

    // ------------------------------------------------------------
    // threshold assembly and compare
    // ------------------------------------------------------------
    wire [11:0] light_low_thr = {light_threshold_shared_nibbles_ff[3:0],
                                 light_low_threshold_low_byte_ff};
    wire [11:0] light_high_thr = {light_high_threshold_high_byte_ff,
                                  light_threshold_shared_nibbles_ff[7:4]};
    // compares use the threshold registers as they stand when the result arrives
    wire prox_near = i_prox_data >= prox_high_threshold_ff;
    wire prox_far = i_prox_data <= prox_low_threshold_ff;
    wire light_below = i_light_data <= light_low_thr;
    wire light_above = i_light_data >= light_high_thr;
    wire light_out = light_below || light_above;

    // ------------------------------------------------------------
    // persistence
    // ------------------------------------------------------------
    wire [4:0] nxt_prox_near_cnt = i_prox_valid ?
        run_next(prox_near_cnt_ff, prox_near) : prox_near_cnt_ff;
    wire [4:0] nxt_prox_far_cnt = i_prox_valid ?
        run_next(prox_far_cnt_ff, prox_far) : prox_far_cnt_ff;
    wire [4:0] nxt_light_out_cnt = i_light_valid ?
        run_next(light_out_cnt_ff, light_out) : light_out_cnt_ff;
    wire prox_set = i_prox_valid && prox_near &&
        (nxt_prox_near_cnt >= prst_count(prox_prst_ff));
    wire prox_clr_hw = i_prox_valid && prox_far &&
        (nxt_prox_far_cnt >= prst_count(prox_prst_ff));
    wire light_set = i_light_valid && light_out &&
        (nxt_light_out_cnt >= prst_count(light_prst_ff));
    wire light_clr_hw = i_light_valid && !light_out;

    // ------------------------------------------------------------
    // flags: a hardware set beats any clear in the same cycle
    // ------------------------------------------------------------
    wire sw_clr_prox = wr_int && !i_reg_wr_data[lptc_pkg::BIT_PROX_FLAG];
    wire sw_clr_light = wr_int && !i_reg_wr_data[lptc_pkg::BIT_LIGHT_FLAG];
    wire nxt_prox_flag = prox_set ? 1'b1 :
        ((prox_clr_hw || sw_clr_prox) ? 1'b0 : prox_flag_ff);
    wire nxt_light_flag = light_set ? 1'b1 :
        ((light_clr_hw || sw_clr_light) ? 1'b0 : light_window_flag_ff);
    wire nxt_int_and = wr_int ? i_reg_wr_data[lptc_pkg::BIT_INT_AND] : int_and_ff;
    wire nxt_int_oe = nxt_int_and ? (nxt_prox_flag && nxt_light_flag) :
        (nxt_prox_flag || nxt_light_flag);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [7:0] int_reg_view = {prox_flag_ff, prox_prst_ff, 1'b0, light_window_flag_ff,
                               light_prst_ff, int_and_ff};
    logic [7:0] nxt_rd_data;
    always_comb begin
        nxt_rd_data = 8'h00;
        unique case (i_reg_addr)
            lptc_pkg::ADDR_INT_CTRL: nxt_rd_data = int_reg_view;
            lptc_pkg::ADDR_PROX_LOW_THRESHOLD: nxt_rd_data = prox_low_threshold_ff;
            lptc_pkg::ADDR_PROX_HIGH_THRESHOLD: nxt_rd_data = prox_high_threshold_ff;
            lptc_pkg::ADDR_LIGHT_LOW_LSB: nxt_rd_data = light_low_threshold_low_byte_ff;
            lptc_pkg::ADDR_LIGHT_SHARED: nxt_rd_data = light_threshold_shared_nibbles_ff;
            lptc_pkg::ADDR_LIGHT_HIGH_MSB: nxt_rd_data = light_high_threshold_high_byte_ff;
            lptc_pkg::ADDR_PROX_RESULT: nxt_rd_data = prox_result_ff;
            lptc_pkg::ADDR_LIGHT_RESULT_LSB: nxt_rd_data = light_result_ff[7:0];
            lptc_pkg::ADDR_LIGHT_RESULT_MSB: nxt_rd_data = {4'h0, light_result_ff[11:8]};
            default: nxt_rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // threshold registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prox_low_threshold_ff <= lptc_pkg::RST_PROX_LOW_THRESHOLD;
            prox_high_threshold_ff <= lptc_pkg::RST_PROX_HIGH_THRESHOLD;
            light_low_threshold_low_byte_ff <= lptc_pkg::RST_LIGHT_LOW_LSB;
            light_threshold_shared_nibbles_ff <= lptc_pkg::RST_LIGHT_SHARED;
            light_high_threshold_high_byte_ff <= lptc_pkg::RST_LIGHT_HIGH_MSB;
        end else begin
            if (wr_ptl) begin
                prox_low_threshold_ff <= i_reg_wr_data;
            end
            if (wr_pth) begin
                prox_high_threshold_ff <= i_reg_wr_data;
            end
            if (wr_ll) begin
                light_low_threshold_low_byte_ff <= i_reg_wr_data;
            end
            if (wr_ls) begin
                light_threshold_shared_nibbles_ff <= i_reg_wr_data;
            end
            if (wr_lh) begin
                light_high_threshold_high_byte_ff <= i_reg_wr_data;
            end
        end
    end

    // ------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prox_result_ff <= lptc_pkg::RST_RESULT;
            light_result_ff <= 12'h000;
        end else begin
            if (i_prox_valid) begin
                prox_result_ff <= i_prox_data;
            end
            if (i_light_valid) begin
                light_result_ff <= i_light_data;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt state
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prox_flag_ff <= 1'b0;
            light_window_flag_ff <= 1'b0;
            prox_prst_ff <= lptc_pkg::RST_INT_CTRL[6:5];
            light_prst_ff <= lptc_pkg::RST_INT_CTRL[2:1];
            int_and_ff <= lptc_pkg::RST_INT_CTRL[0];
            prox_near_cnt_ff <= lptc_pkg::RST_CNT;
            prox_far_cnt_ff <= lptc_pkg::RST_CNT;
            light_out_cnt_ff <= lptc_pkg::RST_CNT;
            o_int_oe_ff <= 1'b0;
        end else begin
            prox_flag_ff <= nxt_prox_flag;
            light_window_flag_ff <= nxt_light_flag;
            if (wr_int) begin
                prox_prst_ff <=
                    i_reg_wr_data[lptc_pkg::BIT_PROX_PRST_HI:lptc_pkg::BIT_PROX_PRST_LO];
                light_prst_ff <=
                    i_reg_wr_data[lptc_pkg::BIT_LIGHT_PRST_HI:lptc_pkg::BIT_LIGHT_PRST_LO];
            end
            int_and_ff <= nxt_int_and;
            prox_near_cnt_ff <= nxt_prox_near_cnt;
            prox_far_cnt_ff <= nxt_prox_far_cnt;
            light_out_cnt_ff <= nxt_light_out_cnt;
            o_int_oe_ff <= nxt_int_oe;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // read data holds between reads so a slow serial shifter can sample it late
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rd_data_ff <= 8'h00;
        end else if (i_reg_rd_en) begin
            o_reg_rd_data_ff <= nxt_rd_data;
        end
    end

    assign o_reg_rd_data = o_reg_rd_data_ff;
    // open-drain pin: only ever pulls low
    assign o_int_o = 1'b0;
    assign o_int_oe = o_int_oe_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_prox_near_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_prox_valid && prox_near && prox_prst_ff == 2'b00) |=> prox_flag_ff)
        else $error("prox flag not set on near result");

    a_prox_far_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_prox_valid && prox_far && !prox_near && prox_prst_ff == 2'b00) |=> !prox_flag_ff)
        else $error("prox flag not cleared on far result");

    a_light_out_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_light_valid && light_out && light_prst_ff == 2'b00) |=> light_window_flag_ff)
        else $error("light flag not set outside window");

    a_light_inside_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_light_valid && !light_below && !light_above) |=> !light_window_flag_ff)
        else $error("light flag high inside window");

    a_pin_combine: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_int_oe == (int_and_ff ? (prox_flag_ff && light_window_flag_ff)
                                : (prox_flag_ff || light_window_flag_ff)))
        else $error("interrupt pin does not match flags");

    a_sw_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (wr_int && !i_reg_wr_data[7] && !i_prox_valid) |=> !prox_flag_ff)
        else $error("prox flag survived zero write");

    a_prst_sixteen: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        ($rose(light_window_flag_ff) && $past(light_prst_ff) == 2'b11)
        |-> light_out_cnt_ff == 5'h10)
        else $error("light flag rose before sixteen results");

    a_result_store: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_prox_valid |=> prox_result_ff == $past(i_prox_data))
        else $error("prox result not stored");

    a_read_thresh: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_reg_rd_en && i_reg_addr == 8'h07 && !i_reg_wr_en)
        |=> o_reg_rd_data == light_high_thr[11:4])
        else $error("high threshold byte misread");

    // flags move only on a new result or a write to the interrupt register
    a_prox_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (!i_prox_valid && !wr_int) |=> $stable(prox_flag_ff))
        else $error("prox flag moved without a result");

    a_light_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (!i_light_valid && !wr_int) |=> $stable(light_window_flag_ff))
        else $error("light flag moved without a result");

    a_light_below_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_light_valid && light_below && light_prst_ff == 2'b00) |=> light_window_flag_ff)
        else $error("light flag not set below window");

    a_pin_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (wr_int && !i_reg_wr_data[lptc_pkg::BIT_PROX_FLAG]
            && !i_reg_wr_data[lptc_pkg::BIT_LIGHT_FLAG] && !i_prox_valid && !i_light_valid)
        |=> !o_int_oe)
        else $error("interrupt pin held after flags cleared");

    a_prox_prst_eight: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        ($rose(prox_flag_ff) && $past(prox_prst_ff) == 2'b10)
        |-> prox_near_cnt_ff >= lptc_pkg::PRST_N8)
        else $error("prox flag rose before eight results");

    a_light_store: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_light_valid |=> light_result_ff == $past(i_light_data))
        else $error("light result not stored");

    a_msb_nibble: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_reg_rd_en && i_reg_addr == lptc_pkg::ADDR_LIGHT_RESULT_MSB)
        |=> o_reg_rd_data[7:4] == 4'h0)
        else $error("light result upper nibble padding not zero");

    a_result_ro: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_reg_wr_en && i_reg_addr == lptc_pkg::ADDR_PROX_RESULT && !i_prox_valid)
        |=> $stable(prox_result_ff))
        else $error("prox result changed by a write");

    a_low_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wr_ptl |=> prox_low_threshold_ff == $past(i_reg_wr_data))
        else $error("prox low threshold write lost");

    a_high_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wr_pth |=> prox_high_threshold_ff == $past(i_reg_wr_data))
        else $error("prox high threshold write lost");

endmodule

// ---- lptc_pkg.sv ----
// register map, reset values and field positions of the light/proximity compare block
package lptc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_INT_CTRL = 8'h02;
    localparam logic [7:0] ADDR_PROX_LOW_THRESHOLD = 8'h03;
    localparam logic [7:0] ADDR_PROX_HIGH_THRESHOLD = 8'h04;
    localparam logic [7:0] ADDR_LIGHT_LOW_LSB = 8'h05;
    localparam logic [7:0] ADDR_LIGHT_SHARED = 8'h06;
    localparam logic [7:0] ADDR_LIGHT_HIGH_MSB = 8'h07;
    localparam logic [7:0] ADDR_PROX_RESULT = 8'h08;
    localparam logic [7:0] ADDR_LIGHT_RESULT_LSB = 8'h09;
    localparam logic [7:0] ADDR_LIGHT_RESULT_MSB = 8'h0A;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_PROX_LOW_THRESHOLD = 8'h00;
    localparam logic [7:0] RST_PROX_HIGH_THRESHOLD = 8'hFF;
    localparam logic [7:0] RST_LIGHT_LOW_LSB = 8'h00;
    localparam logic [7:0] RST_LIGHT_SHARED = 8'hF0;
    localparam logic [7:0] RST_LIGHT_HIGH_MSB = 8'hFF;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [4:0] RST_CNT = 5'h00;

    // ------------------------------------------------------------
    // interrupt register field positions
    // ------------------------------------------------------------
    localparam int BIT_PROX_FLAG = 7;
    localparam int BIT_PROX_PRST_HI = 6;
    localparam int BIT_PROX_PRST_LO = 5;
    localparam int BIT_LIGHT_FLAG = 3;
    localparam int BIT_LIGHT_PRST_HI = 2;
    localparam int BIT_LIGHT_PRST_LO = 1;
    localparam int BIT_INT_AND = 0;

    // ------------------------------------------------------------
    // persistence counts
    // ------------------------------------------------------------
    localparam logic [4:0] PRST_N1 = 5'h01;
    localparam logic [4:0] PRST_N4 = 5'h04;
    localparam logic [4:0] PRST_N8 = 5'h08;
    localparam logic [4:0] PRST_N16 = 5'h10;

endpackage

// ---- lptc_host_model.sv ----
// host model that reaches the compare block through its register port
`timescale 1ns/1ps

module lptc_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_reg_rd_data,
    output logic [7:0] o_reg_addr,
    output logic o_reg_wr_en,
    output logic [7:0] o_reg_wr_data,
    output logic o_reg_rd_en
);
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wr_en = 1'b0;
        o_reg_wr_data = 8'h00;
        o_reg_rd_en = 1'b0;
    end

    // ------------------------------------------------------------
    // register cycles, one strobe cycle each
    // ------------------------------------------------------------
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_core_clk);
        o_reg_addr = addr;
        o_reg_wr_data = data;
        o_reg_wr_en = 1'b1;
        @(negedge i_core_clk);
        o_reg_wr_en = 1'b0;
        // idle lines flip so a stale value never reads as intended
        o_reg_addr = ~addr;
        o_reg_wr_data = ~data;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge i_core_clk);
        o_reg_addr = addr;
        o_reg_rd_en = 1'b1;
        @(negedge i_core_clk);
        o_reg_rd_en = 1'b0;
        o_reg_addr = ~addr;
        // read data is held until the next read, so one more cycle is safe
        @(negedge i_core_clk);
        data = i_reg_rd_data;
    endtask
endmodule

// ---- test_light_prox_threshold_compare.sv ----
// self-checking testbench of the light/proximity threshold compare block
`timescale 1ns/1ps

module test_light_prox_threshold_compare;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic prox_valid = 1'b0;
    logic [7:0] prox_data = 8'h00;
    logic light_valid = 1'b0;
    logic [11:0] light_data = 12'h000;
    logic [7:0] addr;
    logic wr_en;
    logic [7:0] wr_data;
    logic rd_en;
    logic [7:0] rd_data;
    logic int_o;
    logic int_oe;
    int miscompares = 0;
    int samples_checked = 0;

    always #5 clk = ~clk;

    lptc_top i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr),
        .i_reg_wr_en(wr_en), .i_reg_wr_data(wr_data), .i_reg_rd_en(rd_en),
        .i_prox_valid(prox_valid), .i_prox_data(prox_data), .i_light_valid(light_valid),
        .i_light_data(light_data), .o_reg_rd_data(rd_data), .o_int_o(int_o),
        .o_int_oe(int_oe));

    lptc_host_model i_host (.i_core_clk(clk), .i_reg_rd_data(rd_data), .o_reg_addr(addr),
        .o_reg_wr_en(wr_en), .o_reg_wr_data(wr_data), .o_reg_rd_en(rd_en));

    // ------------------------------------------------------------
    // compare and stimulus helpers
    // ------------------------------------------------------------
    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_pin(input logic exp);
        samples_checked++;
        if (int_oe !== exp || int_o !== 1'b0) begin
            miscompares++;
            $display("BAD int_pin expected %b seen %b/%b", exp, int_oe, int_o);
        end
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] got;
        i_host.read_reg(a, got);
        check_byte($sformatf("reg_%h", a), exp, got);
    endtask

    task automatic send(input logic p, input logic [7:0] pd, input logic l, input logic [11:0] ld);
        @(negedge clk);
        prox_valid = p;
        prox_data = pd;
        light_valid = l;
        light_data = ld;
        @(negedge clk);
        prox_valid = 1'b0;
        light_valid = 1'b0;
        prox_data = ~pd;
        light_data = ~ld;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        logic [7:0] rst_tab [0:9];
        rst_tab = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hF0, 8'hFF, 8'h00, 8'h00, 8'h00};
        check_pin(1'b0);
        for (int a = 1; a <= 9; a++) begin
            expect_reg(8'(a + 1), rst_tab[a]);
        end
        i_host.write_reg(8'h08, 8'h55);
        i_host.write_reg(8'h0A, 8'h0F);
        expect_reg(8'h08, 8'h00);
        expect_reg(8'h0A, 8'h00);
        expect_reg(8'h0B, 8'h00);
    endtask

    task automatic t_prox();
        i_host.write_reg(8'h03, 8'h20);
        i_host.write_reg(8'h04, 8'h80);
        expect_reg(8'h03, 8'h20);
        expect_reg(8'h04, 8'h80);
        send(1'b1, 8'h7F, 1'b0, 12'h000);
        expect_reg(8'h02, 8'h00);
        send(1'b1, 8'h80, 1'b0, 12'h000);
        check_pin(1'b1);
        expect_reg(8'h02, 8'h80);
        expect_reg(8'h08, 8'h80);
        send(1'b1, 8'h21, 1'b0, 12'h000);
        expect_reg(8'h02, 8'h80);
        send(1'b1, 8'h20, 1'b0, 12'h000);
        expect_reg(8'h02, 8'h00);
        check_pin(1'b0);
        i_host.write_reg(8'h04, 8'h30);
        send(1'b1, 8'h30, 1'b0, 12'h000);
        expect_reg(8'h02, 8'h80);
        i_host.write_reg(8'h02, 8'h00);
        expect_reg(8'h02, 8'h00);
        check_pin(1'b0);
    endtask

    task automatic t_light();
        i_host.write_reg(8'h05, 8'h23);
        i_host.write_reg(8'h06, 8'hC1);
        i_host.write_reg(8'h07, 8'hAB);
        expect_reg(8'h06, 8'hC1);
        send(1'b0, 8'h00, 1'b1, 12'h124);
        expect_reg(8'h02, 8'h00);
        send(1'b0, 8'h00, 1'b1, 12'h123);
        expect_reg(8'h02, 8'h08);
        expect_reg(8'h09, 8'h23);
        expect_reg(8'h0A, 8'h01);
        send(1'b0, 8'h00, 1'b1, 12'h500);
        expect_reg(8'h02, 8'h00);
        check_pin(1'b0);
        send(1'b0, 8'h00, 1'b1, 12'hABB);
        expect_reg(8'h02, 8'h00);
        send(1'b0, 8'h00, 1'b1, 12'hABC);
        expect_reg(8'h02, 8'h08);
        check_pin(1'b1);
        send(1'b0, 8'h00, 1'b1, 12'hABB);
        expect_reg(8'h02, 8'h00);
    endtask

    task automatic t_persist();
        int n_tab [0:3];
        logic [7:0] ctrl;
        n_tab = '{1, 4, 8, 16};
        for (int k = 0; k < 4; k++) begin
            ctrl = 8'((k << 5) | (k << 1));
            i_host.write_reg(8'h02, ctrl);
            send(1'b1, 8'h28, 1'b1, 12'h500);
            repeat (n_tab[k] - 1) send(1'b1, 8'h90, 1'b1, 12'hF00);
            expect_reg(8'h02, ctrl);
            check_pin(1'b0);
            send(1'b1, 8'h90, 1'b1, 12'hF00);
            expect_reg(8'h02, ctrl | 8'h88);
            check_pin(1'b1);
        end
        i_host.write_reg(8'h02, 8'h00);
        check_pin(1'b0);
    endtask

    task automatic t_and_mode();
        i_host.write_reg(8'h02, 8'h01);
        send(1'b1, 8'h90, 1'b0, 12'h000);
        expect_reg(8'h02, 8'h81);
        check_pin(1'b0);
        send(1'b0, 8'h00, 1'b1, 12'hF00);
        check_pin(1'b1);
        i_host.write_reg(8'h02, 8'h01);
        expect_reg(8'h02, 8'h01);
        check_pin(1'b0);
    endtask

    task automatic complete_run();
        $display("compared %0d values, %0d mismatches", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_reset_values();
        t_prox();
        t_light();
        t_persist();
        t_and_mode();
        complete_run();
    end

    // whole run is a few hundred cycles; this leaves ample margin
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end
endmodule
